// >>> rtl/flsp_pkg.sv
// Summary of operation
// - busy flag is 1 during program, erase or status write, else 0.
// - write enable latch is a status bit; writes, programs, erases refused when 0.
// - five guard bits, set by status write, select region refusing program and erase.
// - guard bits change only while hardware protected mode is not in force.
// - full erase only with low guards 000 and complement 0, or 111 and 1.
// - quad enable 0 makes shared pins protect and hold; 1 makes them data.
// - three one-time lock bits default 0, set singly, cleared only by power cycle.
// - complement bit, default 0, joins guard bits to pick the protected region.
// - suspend sets erase-paused or program-paused flag by the operation suspended.
// - resume and power cycle clear both paused flags.
// - drive field 00 full, 01 three quarters, 10 half, 11 quarter strength.
// - guard mode 00 allows status writes whenever latch is 1, pin ignored.
// - guard mode 01 locks status while protect pin low, unlocked when high.
// - guard mode 10 locks status until power cycle, which returns mode 00.
// - guard mode 11 refuses every status write until power cycle, which returns mode 00.
// - in deep power-down only the release instruction is taken.
// - write enable sets latch; disable, status write, program, erase, reset clear it.
// - quad instructions taken only with quad enable set; host sets it first.
// - status write, write enable, disable need chip select rising on byte boundary.
package flsp_pkg;

  // status word bit positions
  localparam int unsigned BIT_WIP = 0;
  localparam int unsigned BIT_WEL = 1;
  localparam int unsigned BIT_SUS_PRG = 10;
  localparam int unsigned BIT_SUS_ERS = 15;

  // writable fields: guards, modes, quad, complement, drive; locks are or-only
  localparam logic [23:0] WR_MASK  = 24'h6043fc;
  localparam logic [23:0] OTP_MASK = 24'h003800;
  localparam logic [23:0] NV_RESET = 24'h000000;

  // instruction codes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDS0  = 8'h05;
  localparam logic [7:0] OP_RDS1  = 8'h35;
  localparam logic [7:0] OP_RDS2  = 8'h15;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_QPP   = 8'h32;
  localparam logic [7:0] OP_QOR   = 8'h6b;
  localparam logic [7:0] OP_QIOR  = 8'heb;
  localparam logic [7:0] OP_QWR   = 8'he7;
  localparam logic [7:0] OP_QID   = 8'h94;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_BE32  = 8'h52;
  localparam logic [7:0] OP_BE64  = 8'hd8;
  localparam logic [7:0] OP_CE0   = 8'hc7;
  localparam logic [7:0] OP_CE1   = 8'h60;
  localparam logic [7:0] OP_SUSP  = 8'h75;
  localparam logic [7:0] OP_RESM  = 8'h7a;
  localparam logic [7:0] OP_DPD   = 8'hb9;
  localparam logic [7:0] OP_RDPD  = 8'hab;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST   = 8'h99;

  // guard modes
  localparam logic [1:0] GM_SOFT = 2'h0;
  localparam logic [1:0] GM_HARD = 2'h1;
  localparam logic [1:0] GM_LOCK = 2'h2;

  // status write busy time
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SRW_TIME_NS   = 10000;
  localparam int unsigned SRW_CYCLES    = (SRW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SRW_CNT_W     = 16;
  localparam int unsigned ADDR_BYTES    = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_DATA = 2'b11,
    ST_IGN  = 2'b10
  } flsp_state_t;

  typedef struct packed {
    logic       rsv_23;
    logic [1:0] drive_strength;
    logic [4:0] rsv_20_16;
    logic       erase_paused_flag;
    logic       region_complement;
    logic [2:0] secure_lock;
    logic       program_paused_flag;
    logic       quad_enable;
    logic       guard_mode_hi;
    logic       guard_mode_lo;
    logic [4:0] region_guard;
    logic       write_enable_latch;
    logic       write_in_progress;
  } flsp_status_t;

endpackage

// >>> rtl/flsp_sync.sv
`timescale 1ns/1ps
module flsp_sync import flsp_pkg::*; #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  // raw and synchronised levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // two stages; only the second stage is read outside
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule

// >>> rtl/flsp_link.sv
`timescale 1ns/1ps
module flsp_link import flsp_pkg::*; (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // synchronised pins
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  input  wire logic       hold_i,
  // transmit side
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_en_i,
  // receive side
  output logic      [7:0] rx_byte_o,
  output logic            byte_o,
  output logic            cs_fall_o,
  output logic            cs_rise_o,
  output logic            boundary_o,
  // serial out
  output logic            so_o,
  output logic            so_oe_n_o
);
  logic       sclk_d_ff;
  logic       cs_d_ff;
  logic [2:0] bit_ff;
  logic [6:0] rx_sh_ff;
  logic [7:0] rx_byte_ff;
  logic       byte_ff;
  logic [7:0] tx_sh_ff;
  logic       so_ff;

  // edges count only while selected and not held
  wire active_w = !cs_n_i && !hold_i;
  wire rise_w   = sclk_i && !sclk_d_ff && active_w;
  wire fall_w   = !sclk_i && sclk_d_ff && active_w;
  wire last_w   = (bit_ff == 3'h7);

  assign cs_fall_o  = !cs_n_i && cs_d_ff;
  assign cs_rise_o  = cs_n_i && !cs_d_ff;
  assign boundary_o = (bit_ff == 3'h0);

  // sample on rising edge, msb first
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sclk_d_ff  <= 1'b0;
      cs_d_ff    <= 1'b1;
      bit_ff     <= 3'h0;
      rx_sh_ff   <= 7'h00;
      rx_byte_ff <= 8'h00;
      byte_ff    <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_i;
      cs_d_ff   <= cs_n_i;
      byte_ff   <= rise_w && last_w;
      if (cs_n_i) begin
        bit_ff <= 3'h0;
      end else if (rise_w) begin
        bit_ff   <= bit_ff + 3'h1;
        rx_sh_ff <= {rx_sh_ff[5:0], si_i};
        if (last_w) begin
          rx_byte_ff <= {rx_sh_ff, si_i};
        end
      end
    end
  end

  // shift out on falling edge; a new byte loads at each byte start
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tx_sh_ff <= 8'h00;
      so_ff    <= 1'b0;
    end else if (fall_w && boundary_o) begin
      so_ff    <= tx_byte_i[7];
      tx_sh_ff <= {tx_byte_i[6:0], 1'b0};
    end else if (fall_w) begin
      so_ff    <= tx_sh_ff[7];
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  assign rx_byte_o = rx_byte_ff;
  assign byte_o    = byte_ff;
  assign so_o      = so_ff;
  assign so_oe_n_o = !(tx_en_i && active_w);
endmodule

// >>> rtl/flsp_status_reg.sv
`timescale 1ns/1ps
module flsp_status_reg import flsp_pkg::*; (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  // serial pins
  input  wire logic         sclk_i,
  input  wire logic         cs_n_i,
  input  wire logic         si_i,
  input  wire logic         wp_n_i,
  input  wire logic         hold_n_i,
  output logic              so_o,
  output logic              so_oe_n_o,
  // engine side
  input  wire logic         engine_busy_i,
  input  wire logic         engine_is_erase_i,
  input  wire logic         region_hit_i,
  output logic              program_start_o,
  output logic              erase_start_o,
  output logic              chip_erase_start_o,
  output logic              suspend_o,
  output logic              resume_o,
  output logic       [7:0]  cmd_op_o,
  output logic       [23:0] addr_o,
  // configuration outputs
  output flsp_status_t      status_o,
  output logic       [4:0]  region_guard_o,
  output logic              region_complement_o,
  output logic              quad_enable_o,
  output logic       [1:0]  drive_strength_o,
  output logic       [2:0]  secure_lock_o,
  output logic              deep_power_down_o
);
  flsp_state_t          st_ff;
  logic [7:0]           op_ff;
  logic [2:0]           bcnt_ff;
  logic [23:0]          addr_ff;
  logic [23:0]          wdata_ff;
  logic [1:0]           wcnt_ff;
  logic [23:0]          nv_ff;
  logic                 wel_ff;
  logic                 sus_ers_ff;
  logic                 sus_prg_ff;
  logic                 dpd_ff;
  logic                 rsten_ff;
  logic [SRW_CNT_W-1:0] srw_ff;
  logic                 prg_ff;
  logic                 ers_ff;
  logic                 chp_ff;
  logic                 susp_ff;
  logic                 resm_ff;
  flsp_status_t         status_control_word;

  // byte mask for the status bytes actually received
  function automatic logic [23:0] rx_mask(input logic [1:0] n);
    case (n)
      2'h1:    rx_mask = 24'h0000ff;
      2'h2:    rx_mask = 24'h00ffff;
      2'h3:    rx_mask = 24'hffffff;
      default: rx_mask = 24'h000000;
    endcase
  endfunction

  // pin synchronisers
  logic [4:0] pins_s;
  flsp_sync #(.W(5)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({sclk_i, cs_n_i, si_i, wp_n_i, hold_n_i}),
    .sync_o     (pins_s)
  );

  // shared pins act as protect and hold only without quad mode
  wire qe_w     = nv_ff[9];
  wire wp_eff_w = qe_w ? 1'b1 : pins_s[1];
  wire hold_w   = !qe_w && !pins_s[0];

  wire [7:0] rx_w;
  wire       byte_w;
  wire       cs_fall_w;
  wire       cs_rise_w;
  wire       bnd_w;
  wire [7:0] tx_w;
  wire       tx_en_w;

  flsp_link u_link (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .sclk_i     (pins_s[4]),
    .cs_n_i     (pins_s[3]),
    .si_i       (pins_s[2]),
    .hold_i     (hold_w),
    .tx_byte_i  (tx_w),
    .tx_en_i    (tx_en_w),
    .rx_byte_o  (rx_w),
    .byte_o     (byte_w),
    .cs_fall_o  (cs_fall_w),
    .cs_rise_o  (cs_rise_w),
    .boundary_o (bnd_w),
    .so_o       (so_o),
    .so_oe_n_o  (so_oe_n_o)
  );

  // busy covers engine work and the status write timer
  wire wip_w = engine_busy_i || (srw_ff != '0);

  // status word; reserved bits tied to zero
  always_comb begin
    status_control_word                     = '0;
    status_control_word.drive_strength      = nv_ff[22:21];
    status_control_word.erase_paused_flag   = sus_ers_ff;
    status_control_word.region_complement   = nv_ff[14];
    status_control_word.secure_lock         = nv_ff[13:11];
    status_control_word.program_paused_flag = sus_prg_ff;
    status_control_word.quad_enable         = nv_ff[9];
    status_control_word.guard_mode_hi       = nv_ff[8];
    status_control_word.guard_mode_lo       = nv_ff[7];
    status_control_word.region_guard        = nv_ff[6:2];
    status_control_word.write_enable_latch  = wel_ff;
    status_control_word.write_in_progress   = wip_w;
  end

  // read selection
  wire rd0_w = (op_ff == OP_RDS0);
  wire rd1_w = (op_ff == OP_RDS1);
  wire rd2_w = (op_ff == OP_RDS2);
  assign tx_en_w = (st_ff == ST_DATA) && (rd0_w || rd1_w || rd2_w);
  assign tx_w    = rd2_w ? status_control_word[23:16] :
                   rd1_w ? status_control_word[15:8] : status_control_word[7:0];

  // opcode screening: quad ops need quad enable, deep power-down takes only release
  wire quad_op_w = (rx_w == OP_QPP) || (rx_w == OP_QOR) || (rx_w == OP_QIOR) ||
                   (rx_w == OP_QWR) || (rx_w == OP_QID);
  wire accept_w  = dpd_ff ? (rx_w == OP_RDPD) : !(quad_op_w && !qe_w);

  // execution happens only when chip select rises on a byte boundary
  wire ex_w = cs_rise_w && bnd_w && (st_ff == ST_DATA);
  wire [1:0] gm_w = nv_ff[8:7];
  wire sr_open_w = (gm_w == GM_SOFT) ||
                   ((gm_w == GM_HARD) && wp_eff_w);
  wire chip_ok_w = ((nv_ff[4:2] == 3'h0) && !nv_ff[14]) ||
                   ((nv_ff[4:2] == 3'h7) && nv_ff[14]);
  wire idle_w    = ex_w && !wip_w;
  wire wren_w    = idle_w && (op_ff == OP_WREN);
  wire wrdi_w    = idle_w && (op_ff == OP_WRDI);
  wire wrsr_w    = idle_w && wel_ff && (op_ff == OP_WRSR) && (wcnt_ff != 2'h0);
  wire srw_go_w  = wrsr_w && sr_open_w;
  wire addr_ok_w = (bcnt_ff >= 3'(ADDR_BYTES));
  wire pgm_w     = idle_w && wel_ff && addr_ok_w && !region_hit_i &&
                   ((op_ff == OP_PP) || ((op_ff == OP_QPP) && qe_w));
  wire ers_w     = idle_w && wel_ff && (bcnt_ff == 3'(ADDR_BYTES)) && !region_hit_i &&
                   ((op_ff == OP_SE) || (op_ff == OP_BE32) || (op_ff == OP_BE64));
  wire chp_w     = idle_w && wel_ff && chip_ok_w &&
                   ((op_ff == OP_CE0) || (op_ff == OP_CE1));
  wire susp_w    = ex_w && (op_ff == OP_SUSP) && engine_busy_i;
  wire resm_w    = ex_w && (op_ff == OP_RESM) && (sus_ers_ff || sus_prg_ff);
  wire srst_w    = idle_w && (op_ff == OP_RST) && rsten_ff;
  wire [23:0] m_w = rx_mask(wcnt_ff);

  // frame state, opcode and payload capture
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_ff    <= ST_IDLE;
      op_ff    <= 8'h00;
      bcnt_ff  <= 3'h0;
      addr_ff  <= 24'h000000;
      wdata_ff <= 24'h000000;
      wcnt_ff  <= 2'h0;
    end else if (cs_rise_w) begin
      st_ff <= ST_IDLE;
    end else if (cs_fall_w) begin
      st_ff    <= ST_CMD;
      bcnt_ff  <= 3'h0;
      wdata_ff <= 24'h000000;
      wcnt_ff  <= 2'h0;
    end else if (byte_w && (st_ff == ST_CMD)) begin
      op_ff <= rx_w;
      st_ff <= accept_w ? ST_DATA : ST_IGN;
    end else if (byte_w && (st_ff == ST_DATA)) begin
      if (bcnt_ff != 3'h7) begin
        bcnt_ff <= bcnt_ff + 3'h1;
      end
      if (bcnt_ff < 3'(ADDR_BYTES)) begin
        addr_ff <= {addr_ff[15:0], rx_w};
      end
      if (wcnt_ff != 2'h3) begin
        wdata_ff <= wdata_ff | ({16'h0000, rx_w} << {wcnt_ff, 3'b000});
        wcnt_ff  <= wcnt_ff + 2'h1;
      end
    end
  end

  // non-volatile fields; power-on returns guard mode to 00
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      nv_ff <= NV_RESET;
    end else if (srw_go_w) begin
      nv_ff <= (nv_ff & ~(WR_MASK & m_w)) | (wdata_ff & WR_MASK & m_w) |
               (wdata_ff & OTP_MASK & m_w);
    end
  end

  // latch, pause flags, power-down and reset arming
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wel_ff     <= 1'b0;
      sus_ers_ff <= 1'b0;
      sus_prg_ff <= 1'b0;
      dpd_ff     <= 1'b0;
      rsten_ff   <= 1'b0;
    end else begin
      if (wren_w) begin
        wel_ff <= 1'b1;
      end else if (wrdi_w || wrsr_w || pgm_w || ers_w || chp_w || srst_w) begin
        wel_ff <= 1'b0;
      end
      if (susp_w) begin
        sus_ers_ff <= sus_ers_ff || engine_is_erase_i;
        sus_prg_ff <= sus_prg_ff || !engine_is_erase_i;
      end else if (resm_w) begin
        sus_ers_ff <= 1'b0;
        sus_prg_ff <= 1'b0;
      end
      if (idle_w && (op_ff == OP_DPD)) begin
        dpd_ff <= 1'b1;
      end else if (ex_w && (op_ff == OP_RDPD)) begin
        dpd_ff <= 1'b0;
      end
      if (ex_w) begin
        rsten_ff <= (op_ff == OP_RSTEN);
      end
    end
  end

  // status write busy timer and engine strobes
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      srw_ff  <= '0;
      prg_ff  <= 1'b0;
      ers_ff  <= 1'b0;
      chp_ff  <= 1'b0;
      susp_ff <= 1'b0;
      resm_ff <= 1'b0;
    end else begin
      if (srw_go_w) begin
        srw_ff <= SRW_CNT_W'(SRW_CYCLES);
      end else if (srw_ff != '0) begin
        srw_ff <= srw_ff - 1'b1;
      end
      prg_ff  <= pgm_w;
      ers_ff  <= ers_w;
      chp_ff  <= chp_w;
      susp_ff <= susp_w;
      resm_ff <= resm_w;
    end
  end

  assign status_o            = status_control_word;
  assign region_guard_o      = nv_ff[6:2];
  assign region_complement_o = nv_ff[14];
  assign quad_enable_o       = qe_w;
  assign drive_strength_o    = nv_ff[22:21];
  assign secure_lock_o       = nv_ff[13:11];
  assign deep_power_down_o   = dpd_ff;
  assign program_start_o     = prg_ff;
  assign erase_start_o       = ers_ff;
  assign chip_erase_start_o  = chp_ff;
  assign suspend_o           = susp_ff;
  assign resume_o            = resm_ff;
  assign cmd_op_o            = op_ff;
  assign addr_o              = addr_ff;

  a_srw_busy: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    srw_go_w |=> status_control_word.write_in_progress [*8])
    else $error("busy flag dropped during status write");
  a_wel_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (program_start_o || erase_start_o || chip_erase_start_o) |-> $past(wel_ff))
    else $error("engine started without write enable");
  a_region_block: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (program_start_o || erase_start_o) |-> !$past(region_hit_i))
    else $error("program or erase inside guarded region");
  a_guard_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !sr_open_w |=> $stable(nv_ff))
    else $error("status changed while protected");
  a_chip_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    chip_erase_start_o |-> $past(chip_ok_w))
    else $error("chip erase with guard bits set");
  a_otp_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ##1 (($past(nv_ff[13:11]) & ~nv_ff[13:11]) == 3'h0))
    else $error("lock bit cleared");
  a_pause_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (susp_w && engine_is_erase_i) |=> sus_ers_ff && suspend_o)
    else $error("erase suspend flag not set");
  a_pause_clr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (resm_w && !susp_w) |=> !sus_ers_ff && !sus_prg_ff && resume_o)
    else $error("paused flags not cleared on resume");
  a_dpd_only: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (dpd_ff && ex_w) |-> (op_ff == OP_RDPD))
    else $error("instruction taken in deep power-down");
  a_wel_bound: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(wel_ff) |-> $past(cs_rise_w && bnd_w))
    else $error("latch set off byte boundary");
  a_wrdi_clr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wrdi_w |=> !wel_ff)
    else $error("write disable left latch set");
endmodule

// >>> verif/flsp_host.sv
`timescale 1ns/1ps
module flsp_host (
  // pacing clock
  input  wire logic core_clk_i,
  // link pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i
);
  // idle: deselected, clock parked low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // mode 0 frame, msb first; rx keeps the last eight bits read
  task automatic frame(input int nbits, input logic [31:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge core_clk_i);
    cs_n_o = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      si_o = tx[i];
      repeat (4) @(negedge core_clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge core_clk_i);
      rx = {rx[6:0], so_i}; // sampled late so the falling-edge shift has settled
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge core_clk_i);
    cs_n_o = 1'b1;
    si_o   = ~si_o; // released line must not keep its last value
    repeat (8) @(negedge core_clk_i);
  endtask
endmodule

// >>> verif/flsp_status_reg_tb.sv
`timescale 1ns/1ps
module flsp_status_reg_tb;
  import flsp_pkg::*;
  // clock, reset and stimulus
  logic         core_clk_i = 1'b0;
  logic         rst_n_i    = 1'b0;
  logic         wp_n       = 1'b1;
  logic         eng_busy   = 1'b0;
  logic         eng_erase  = 1'b0;
  logic         hit        = 1'b0;
  logic         sclk, cs_n, si, so, so_oe_n, so_w;
  logic         pp_st, er_st, ce_st, sus, res, quad, cmp, dpd;
  logic [7:0]   op;
  logic [23:0]  addr;
  logic [4:0]   guard;
  logic [1:0]   drv;
  logic [2:0]   lock;
  flsp_status_t status;
  int           n_errors, n_compared, n_pp, n_ce, n_sus, n_res, n_er;

  always #50 core_clk_i = ~core_clk_i;
  // undriven so line toggles so a stale bit cannot pass
  assign so_w = so_oe_n ? core_clk_i : so;

  // strobe counters
  always @(posedge core_clk_i) begin
    if (pp_st === 1'b1) n_pp++;
    if (ce_st === 1'b1) n_ce++;
    if (er_st === 1'b1) n_er++;
    if (sus === 1'b1) n_sus++;
    if (res === 1'b1) n_res++;
  end

  flsp_host host (.core_clk_i(core_clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_w));

  flsp_status_reg DUT (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
    .wp_n_i(wp_n), .hold_n_i(1'b1), .so_o(so), .so_oe_n_o(so_oe_n),
    .engine_busy_i(eng_busy), .engine_is_erase_i(eng_erase), .region_hit_i(hit),
    .program_start_o(pp_st), .erase_start_o(er_st), .chip_erase_start_o(ce_st),
    .suspend_o(sus), .resume_o(res), .cmd_op_o(op), .addr_o(addr), .status_o(status),
    .region_guard_o(guard), .region_complement_o(cmp), .quad_enable_o(quad),
    .drive_strength_o(drv), .secure_lock_o(lock), .deep_power_down_o(dpd)
  );

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    logic [7:0] r;
    host.frame(8, {24'h0, c}, r);
  endtask

  // bounded wait for the status write timer
  task automatic idle();
    int i;
    for (i = 0; i < 300 && status.write_in_progress !== 1'b0; i++) @(negedge core_clk_i);
    if (i == 300) begin
      n_errors++;
      give_verdict();
    end
  endtask

  // enable then write three bytes; acc says whether busy must follow
  task automatic wrsr(input logic [7:0] b0, b1, b2, input logic acc);
    logic [7:0] r;
    cmd(OP_WREN);
    host.frame(32, {OP_WRSR, b0, b1, b2}, r);
    chk("busy after write", {23'h0, status.write_in_progress}, {23'h0, acc});
    idle();
    chk("latch after write", {23'h0, status.write_enable_latch}, 24'h0);
  endtask

  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] r;
    host.frame(16, {16'h0, c, 8'h00}, r);
    chk("serial status byte", {16'h0, r}, {16'h0, exp});
  endtask

  task automatic pwr();
    rst_n_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
  endtask

  // main sequence
  initial begin
    logic [7:0] r;
    repeat (3) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    chk("status at reset", status, 24'h0);
    rd(OP_RDS0, 8'h00);
    host.frame(7, 32'h03, r);
    chk("latch short frame", {23'h0, status.write_enable_latch}, 24'h0);
    cmd(OP_WREN);
    chk("latch set", {23'h0, status.write_enable_latch}, 24'h1);
    cmd(OP_WRDI);
    chk("latch cleared", {23'h0, status.write_enable_latch}, 24'h0);
    host.frame(32, {OP_WRSR, 24'h1c0000}, r);
    chk("write without latch", status, 24'h0);
    cmd(OP_WREN);
    host.frame(32, {OP_QPP, 24'h001000}, r);
    chk("quad refused", n_pp, 0);
    hit = 1'b1;
    cmd(OP_WREN);
    host.frame(32, {OP_PP, 24'h001000}, r);
    chk("program in guarded region", n_pp, 0);
    hit = 1'b0;
    cmd(OP_WREN);
    host.frame(32, {OP_PP, 24'h001000}, r);
    chk("program started", n_pp, 1);
    chk("program address", addr, 24'h001000);
    chk("latch after program", {23'h0, status.write_enable_latch}, 24'h0);
    cmd(OP_WREN);
    host.frame(32, {OP_SE, 24'h002000}, r);
    chk("sector erase started", n_er, 1);
    chk("last opcode", {16'h0, op}, {16'h0, OP_SE});
    chk("erase address", addr, 24'h002000);
    chk("latch after erase", {23'h0, status.write_enable_latch}, 24'h0);
    for (int d = 0; d < 4; d++) begin
      wrsr(8'h00, 8'h00, {1'b1, d[1:0], 5'h1f}, 1'b1);
      chk("drive", {22'h0, drv}, d);
      chk("byte 2", {16'h0, status[23:16]}, {16'h0, 1'b0, d[1:0], 5'h0});
    end
    wrsr(8'h1c, 8'h42, 8'h00, 1'b1);
    chk("status word", status, 24'h00421c);
    chk("guards", {19'h0, guard}, 24'h7);
    chk("complement", {23'h0, cmp}, 24'h1);
    chk("quad", {23'h0, quad}, 24'h1);
    rd(OP_RDS1, 8'h42);
    cmd(OP_WREN);
    cmd(OP_CE0);
    chk("chip erase all 1", n_ce, 1);
    wrsr(8'h1c, 8'h00, 8'h00, 1'b1);
    cmd(OP_WREN);
    cmd(OP_CE1);
    chk("chip erase refused", n_ce, 1);
    wrsr(8'h00, 8'h00, 8'h00, 1'b1);
    cmd(OP_WREN);
    cmd(OP_CE1);
    chk("chip erase all 0", n_ce, 2);
    wrsr(8'h00, 8'h08, 8'h00, 1'b1);
    wrsr(8'h00, 8'h00, 8'h00, 1'b1);
    chk("lock kept", {21'h0, lock}, 24'h1);
    wrsr(8'h80, 8'h30, 8'h00, 1'b1);
    chk("locks", {21'h0, lock}, 24'h7);
    wp_n = 1'b0;
    wrsr(8'h84, 8'h00, 8'h00, 1'b0);
    chk("guards wp low", {19'h0, guard}, 24'h0);
    wp_n = 1'b1;
    wrsr(8'h84, 8'h00, 8'h00, 1'b1);
    chk("guards wp high", {19'h0, guard}, 24'h1);
    wrsr(8'h04, 8'h01, 8'h00, 1'b1);
    wrsr(8'h00, 8'h00, 8'h00, 1'b0);
    chk("lock down", {19'h0, guard}, 24'h1);
    eng_busy = 1'b1;
    eng_erase = 1'b1;
    cmd(OP_SUSP);
    chk("busy from engine", {23'h0, status.write_in_progress}, 24'h1);
    chk("erase paused", {23'h0, status.erase_paused_flag}, 24'h1);
    eng_busy = 1'b0;
    cmd(OP_RESM);
    chk("resume", n_res, 1);
    chk("flags cleared", {22'h0, status[15], status[10]}, 24'h0);
    eng_busy = 1'b1;
    eng_erase = 1'b0;
    cmd(OP_SUSP);
    chk("program paused", {23'h0, status.program_paused_flag}, 24'h1);
    chk("suspends", n_sus, 2);
    eng_busy = 1'b0;
    pwr();
    chk("status after power cycle", status, 24'h0);
    cmd(OP_DPD);
    chk("power-down entered", {23'h0, dpd}, 24'h1);
    cmd(OP_WREN);
    chk("ignored in power-down", {23'h0, status.write_enable_latch}, 24'h0);
    cmd(OP_RDPD);
    chk("released", {23'h0, dpd}, 24'h0);
    cmd(OP_WREN);
    cmd(OP_RSTEN);
    cmd(OP_RST);
    chk("latch after soft reset", {23'h0, status.write_enable_latch}, 24'h0);
    wrsr(8'h84, 8'h01, 8'h00, 1'b1);
    wrsr(8'h00, 8'h00, 8'h00, 1'b0);
    chk("permanent lock", {19'h0, guard}, 24'h1);
    give_verdict();
  end
endmodule
